// *** adc_cycle_ctrl.v ***
// cycle control of a delta-sigma converter: power-on reset, conversion, sleep, serial data and config
`timescale 1ns/1ns
`include "adc_cycle_consts.vh"

// What this block does
// - starts converting after power-up; sleeps when each conversion completes
// - stays asleep while chip select is high after a conversion
// - holds the finished result unchanged in the shift register while asleep
// - chip select low while asleep wakes into the data and config state
// - chip select high before any rising serial clock returns to sleep
// - chip select high after a rising serial clock aborts and starts converting
// - shifted word is the conversion just finished, one word per conversion
// - output bit changes on falling serial clock; host samples on rising
// - serial config input sampled on each of the first 16 rising serial clocks in data state
// - config received applies from the following conversion on, until a full new one replaces it
// - data state ends after 24 bits or chip select high; then converts if any serial clock rose, else sleeps
// - clock and free-running modes come only from pin driving, no programming
// - first conversion after a config change is valid, no settling conversions
// - every conversion contains offset and full-scale calibration
// - held in internal reset while supply monitor reports low supply
// - supply rising starts a power-on reset of about 4 ms
// - power-on reset clears internal registers, but loads the default config and sets busy, reset and output-disable flags
// - first conversion uses default channels, rejection, speed and gain
// - new config accepted during the first data state after reset
// - overrange and underrange reported with distinct codes
// - word: status, zero, sign, 17 result bits msb first, four zeros
// - output floats with chip select high; else busy high, ready low
// - serial clock low at power-up or chip select fall selects external clock
// - falling edge of 24th clock drives output high for next conversion
module adc_cycle_ctrl #(
  parameter CFG_BITS = `CFG_BITS,
  parameter POR_W = 20,
  parameter [POR_W-1:0] POR_CYCLES = `POR_CLK_CYCLES,
  parameter CONV_W = 12,
  parameter [CONV_W-1:0] CONV_OSC_CYCLES = `CONV_OSC_CYCLES,
  parameter [CONV_W-1:0] CAL_OSC_CYCLES = `CAL_OSC_CYCLES,
  parameter DIV_W = 8,
  parameter [DIV_W-1:0] ISCK_HALF = `ISCK_HALF_CYCLES
) (
  input wire REF_CLK_I,
  input wire RSTN_I,
  input wire SUPPLY_OK_I,
  input wire CONV_OSC_I,
  input wire CSN_I,
  input wire SCK_I,
  output wire SCK_O,
  output wire SCK_OE_N_O,
  input wire SERIAL_CONFIG_IN_I,
  output wire SERIAL_RESULT_OUT_O,
  output wire SERIAL_RESULT_OUT_OE_N_O,
  input wire ADC_SIGN_I,
  input wire [`RESULT_BITS-1:0] ADC_DATA_I,
  input wire ADC_OVER_I,
  input wire ADC_UNDER_I,
  output wire [CFG_BITS-1:0] CONFIG_O,
  output wire POR_ACTIVE_O,
  output wire CONV_ACTIVE_O,
  output wire CAL_ACTIVE_O,
  output wire CONV_DONE_O,
  output wire SLEEP_O,
  output wire INT_SCK_MODE_O
);

  // ==========================================================
  // states
  localparam [1:0] ST_POR = 2'h0;
  localparam [1:0] ST_CONV = 2'h1;
  localparam [1:0] ST_SLEEP = 2'h2;
  localparam [1:0] ST_DATA = 2'h3;
  localparam [CFG_BITS-1:0] CFG_RESET = `CFG_DEFAULT;

  // ==========================================================
  // pin synchronisers
  wire [4:0] pins_s;
  wire supply_s;
  wire osc_s;
  wire sdi_s;
  wire sck_s;
  wire csn_s;

  // chip select enters inverted, so cleared flops read as deselected
  // and the result output is not driven for two cycles after reset
  adc_sync2 #(
    .W(5)
  ) u_sync (
    .clk_i(REF_CLK_I),
    .rstn_i(RSTN_I),
    .d_i({SUPPLY_OK_I, CONV_OSC_I, SERIAL_CONFIG_IN_I, SCK_I, ~CSN_I}),
    .q_o(pins_s)
  );

  assign supply_s = pins_s[4];
  assign osc_s = pins_s[3];
  assign sdi_s = pins_s[2];
  assign sck_s = pins_s[1];
  // undo the inversion taken into the synchroniser
  assign csn_s = ~pins_s[0];

  // ==========================================================
  // state registers
  reg [1:0] state_q;
  reg [POR_W-1:0] por_cnt_q;
  reg [CONV_W-1:0] conv_cnt_q;
  reg osc_p_q;
  reg sck_p_q;
  reg int_mode_q;
  reg isck_q;
  reg isck_oe_n_q;
  reg [DIV_W-1:0] div_q;
  reg [4:0] rise_cnt_q;
  reg [4:0] fall_cnt_q;
  reg [`WORD_BITS-1:0] out_q;
  reg sdo_q;
  reg sdo_oe_n_q;
  reg [CFG_BITS-1:0] cfg_sh_q;
  reg [CFG_BITS-1:0] cfg_q;
  reg cal_q;
  reg conv_active_q;
  reg done_q;
  reg sleep_q;
  reg por_q;

  // ==========================================================
  // edge detection on synchronised pins
  wire osc_rise;
  wire ext_rise;
  wire ext_fall;
  wire isck_run;
  wire isck_tick;
  wire sck_rise;
  wire sck_fall;

  assign osc_rise = osc_s & ~osc_p_q;
  assign ext_rise = sck_s & ~sck_p_q;
  assign ext_fall = ~sck_s & sck_p_q;

  // internal clock runs only in data state with chip select low
  // stopping after 24 falls leaves the line to its pull-up between frames
  assign isck_run = (state_q == ST_DATA) && int_mode_q && !csn_s && (fall_cnt_q != `CNT_FULL);
  assign isck_tick = isck_run && (div_q == ISCK_HALF - 1'b1);

  // one pair of strobes serves both clock sources, so the cycle is the same
  // clock source by pin mode only
  assign sck_rise = int_mode_q ? (isck_tick & ~isck_q) : ext_rise;
  assign sck_fall = int_mode_q ? (isck_tick & isck_q) : ext_fall;

  // ==========================================================
  // result word assembly with range codes
  wire res_sig;
  wire [`RESULT_BITS-1:0] res_mag;
  wire [`WORD_BITS-1:0] res_word;

  // range codes replace sign and magnitude; each equals a word that in-range data can also give
  // distinct over and under codes
  assign res_sig = ADC_OVER_I ? `OVER_SIG : (ADC_UNDER_I ? `UNDER_SIG : ADC_SIGN_I);
  assign res_mag = ADC_OVER_I ? `OVER_MAG : (ADC_UNDER_I ? `UNDER_MAG : ADC_DATA_I);
  assign res_word = {`EOC_READY, `DMY_BIT, res_sig, res_mag, `TAIL_BITS};

  // ==========================================================
  // conversion start shared by the two converting exits from data state, abort and 24th fall
  task start_conv;
    begin
      state_q <= ST_CONV;
      conv_cnt_q <= {CONV_W{1'b0}};
      conv_active_q <= 1'b1;
      sleep_q <= 1'b0;
      // a readout cut short before all 16 config bits keeps the old settings
      // new config only for the next conversion
      if (rise_cnt_q >= CFG_BITS) begin
        cfg_q <= cfg_sh_q;
      end
    end
  endtask

  // ==========================================================
  // internal serial clock divider
  // restarts whenever the clock stops, so each frame opens with a full low phase
  always @(posedge REF_CLK_I) begin
    if (!RSTN_I || !supply_s) begin
      div_q <= {DIV_W{1'b0}};
      isck_q <= 1'b0;
      isck_oe_n_q <= 1'b1;
    end else begin
      isck_oe_n_q <= ~isck_run;
      if (!isck_run) begin
        div_q <= {DIV_W{1'b0}};
        isck_q <= 1'b0;
      end else if (isck_tick) begin
        div_q <= {DIV_W{1'b0}};
        isck_q <= ~isck_q;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // main cycle state machine
  always @(posedge REF_CLK_I) begin
    // supply loss takes the same path as the reset pin
    // low supply holds internal reset
    if (!RSTN_I || !supply_s) begin
      state_q <= ST_POR;
      por_cnt_q <= {POR_W{1'b0}};
      conv_cnt_q <= {CONV_W{1'b0}};
      osc_p_q <= 1'b0;
      sck_p_q <= 1'b0;
      int_mode_q <= 1'b0;
      rise_cnt_q <= `CNT_ZERO;
      fall_cnt_q <= `CNT_ZERO;
      out_q <= {`WORD_BITS{1'b0}};
      sdo_q <= `EOC_BUSY;
      sdo_oe_n_q <= 1'b1;
      cfg_sh_q <= {CFG_BITS{1'b0}};
      cfg_q <= CFG_RESET;
      cal_q <= 1'b0;
      conv_active_q <= 1'b0;
      done_q <= 1'b0;
      sleep_q <= 1'b0;
      por_q <= 1'b1;
    end else begin
      osc_p_q <= osc_s;
      sck_p_q <= sck_s;
      done_q <= 1'b0;
      // output floats whenever chip select is high
      sdo_oe_n_q <= csn_s;
      case (state_q)
        ST_POR: begin
          if (por_cnt_q == POR_CYCLES - 1'b1) begin
            por_q <= 1'b0;
            // mode is latched here and again at every wake-up
            // clock mode strap at power-up
            int_mode_q <= sck_s;
            // first conversion starts on its own
            state_q <= ST_CONV;
            conv_cnt_q <= {CONV_W{1'b0}};
            conv_active_q <= 1'b1;
          end else begin
            por_cnt_q <= por_cnt_q + 1'b1;
          end
        end
        ST_CONV: begin
          sdo_q <= `EOC_BUSY;
          cal_q <= (conv_cnt_q < CAL_OSC_CYCLES);
          // result sampled on the last step, so the word is never a stale one
          // oscillator edges time the conversion
          if (osc_rise) begin
            if (conv_cnt_q == CONV_OSC_CYCLES - 1'b1) begin
              out_q <= res_word;
              done_q <= 1'b1;
              conv_active_q <= 1'b0;
              cal_q <= 1'b0;
              state_q <= ST_SLEEP;
              sleep_q <= 1'b1;
              sdo_q <= `EOC_READY;
            end else begin
              conv_cnt_q <= conv_cnt_q + 1'b1;
            end
          end
        end
        ST_SLEEP: begin
          sdo_q <= `EOC_READY;
          // stay asleep while chip select high
          if (!csn_s) begin
            state_q <= ST_DATA;
            sleep_q <= 1'b0;
            // clock mode sampled at chip select fall
            int_mode_q <= sck_s;
            rise_cnt_q <= `CNT_ZERO;
            fall_cnt_q <= `CNT_ZERO;
            sdo_q <= out_q[`WORD_BITS-1];
          end
        end
        ST_DATA: begin
          // a rise and a fall never share a cycle, so one branch at a time is enough
          if (csn_s) begin
            if (rise_cnt_q == `CNT_ZERO) begin
              // no clock seen, back to sleep
              state_q <= ST_SLEEP;
              sleep_q <= 1'b1;
            end else begin
              start_conv;
              sdo_q <= `EOC_BUSY;
            end
          end else if (sck_rise && rise_cnt_q != `CNT_FULL) begin
            rise_cnt_q <= rise_cnt_q + `CNT_ONE;
            // config bit taken on rising edge
            if (rise_cnt_q < CFG_BITS) begin
              // accepted in any data state, first included
              cfg_sh_q <= {cfg_sh_q[CFG_BITS-2:0], sdi_s};
            end
          end else if (sck_fall && rise_cnt_q > fall_cnt_q) begin
            fall_cnt_q <= fall_cnt_q + `CNT_ONE;
            if (fall_cnt_q == `CNT_LAST) begin
              // 24th falling edge marks new conversion
              sdo_q <= `EOC_BUSY;
              start_conv;
            end else begin
              out_q <= {out_q[`WORD_BITS-2:0], 1'b0};
              sdo_q <= out_q[`WORD_BITS-2];
            end
          end
        end
        default: begin
          state_q <= ST_POR;
        end
      endcase
    end
  end

  // ==========================================================
  // outputs straight from flops
  // no output is combinational, so the pins cannot glitch
  // config held fixed for a whole conversion, so each result is valid
  assign CONFIG_O = cfg_q;
  assign SCK_O = isck_q;
  assign SCK_OE_N_O = isck_oe_n_q;
  assign SERIAL_RESULT_OUT_O = sdo_q;
  assign SERIAL_RESULT_OUT_OE_N_O = sdo_oe_n_q;
  assign POR_ACTIVE_O = por_q;
  assign CONV_ACTIVE_O = conv_active_q;
  assign CAL_ACTIVE_O = cal_q;
  assign CONV_DONE_O = done_q;
  assign SLEEP_O = sleep_q;
  assign INT_SCK_MODE_O = int_mode_q;

endmodule

// *** adc_cycle_consts.vh ***
// named constants for the converter cycle control block
`ifndef ADC_CYCLE_CONSTS_VH
`define ADC_CYCLE_CONSTS_VH

// ==========================================================
// clock and timing
// power-on reset of 4 ms counted in 4 ns clock cycles
`define POR_CLK_CYCLES 20'hf4240
`define CONV_OSC_CYCLES 12'h800
`define CAL_OSC_CYCLES 12'h100
`define ISCK_HALF_CYCLES 8'h08

// ==========================================================
// output word layout
`define WORD_BITS 24
`define RESULT_BITS 17
`define EOC_READY 1'h0
`define EOC_BUSY 1'h1
`define DMY_BIT 1'h0
`define TAIL_BITS 4'h0
`define OVER_SIG 1'h1
`define OVER_MAG 17'h10000
`define UNDER_SIG 1'h0
`define UNDER_MAG 17'h00000

// ==========================================================
// serial edge counting
`define CNT_ZERO 5'h00
`define CNT_ONE 5'h01
`define CNT_LAST 5'h17
`define CNT_FULL 5'h18

// ==========================================================
// configuration word
// [3:0] positive channel, [7:4] negative channel, [9:8] rejection,
// [10] speed, [11] temperature sensor, [14:12] gain, [15] spare
`define CFG_BITS 16
`define CFG_DEFAULT 16'h0010

`endif

// *** adc_sync2.v ***
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ns

module adc_sync2 #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rstn_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);

  reg [W-1:0] meta_q;

  // ==========================================================
  // first stage feeds only the second stage
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_q <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

// *** adc_cycle_ctrl_sva.sv ***
// port assertions for the converter cycle control block
`timescale 1ns/1ns
module adc_cycle_ctrl_sva #(
  parameter CFG_BITS = 16
) (
  input wire REF_CLK_I,
  input wire RSTN_I,
  input wire CSN_I,
  input wire SCK_OE_N_O,
  input wire SERIAL_RESULT_OUT_O,
  input wire SERIAL_RESULT_OUT_OE_N_O,
  input wire [CFG_BITS-1:0] CONFIG_O,
  input wire POR_ACTIVE_O,
  input wire CONV_ACTIVE_O,
  input wire CAL_ACTIVE_O,
  input wire CONV_DONE_O,
  input wire SLEEP_O
);
  // ==========================================
  // state cycle
  default clocking @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  chk_done_sleep: assert property (CONV_DONE_O |-> ##[0:1] SLEEP_O)
    else $error("no sleep after conversion end");
  chk_done_cause: assert property (CONV_DONE_O |-> $past(CONV_ACTIVE_O) && !CAL_ACTIVE_O)
    else $error("conversion end without conversion");
  chk_por_conv: assert property ($fell(POR_ACTIVE_O) |-> ##[0:1] CONV_ACTIVE_O)
    else $error("no conversion after power-on reset");
  chk_sleep_hold: assert property (CSN_I [*4] ##0 SLEEP_O |=> SLEEP_O || POR_ACTIVE_O)
    else $error("sleep left with select high");
  chk_cal_first: assert property ($rose(CONV_ACTIVE_O) |-> ##[0:3] CAL_ACTIVE_O)
    else $error("conversion without calibration");
  chk_cfg_change: assert property ($changed(CONFIG_O) |-> CONV_ACTIVE_O || POR_ACTIVE_O)
    else $error("config changed outside conversion start");
  // ==========================================
  // serial output
  chk_sdo_float: assert property (CSN_I [*4] |-> SERIAL_RESULT_OUT_OE_N_O)
    else $error("output driven with select high");
  chk_sdo_drive: assert property ((!CSN_I) [*4] |-> !SERIAL_RESULT_OUT_OE_N_O || POR_ACTIVE_O)
    else $error("output floats with select low");
  chk_busy_high: assert property (CONV_ACTIVE_O && $past(CONV_ACTIVE_O) && !SERIAL_RESULT_OUT_OE_N_O
    |-> SERIAL_RESULT_OUT_O)
    else $error("busy status not high");
  chk_ready_low: assert property ($fell(SLEEP_O) && !POR_ACTIVE_O
    |-> !SERIAL_RESULT_OUT_O && !SERIAL_RESULT_OUT_OE_N_O)
    else $error("ready status not low at wake-up");
  // main scenarios reached
  cover property (CONV_DONE_O);
  cover property ($fell(SCK_OE_N_O));
  cover property (CONV_ACTIVE_O && !SERIAL_RESULT_OUT_OE_N_O);
endmodule
bind adc_cycle_ctrl adc_cycle_ctrl_sva #(.CFG_BITS(CFG_BITS)) adc_cycle_ctrl_sva_i (
  .REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .CSN_I(CSN_I), .SCK_OE_N_O(SCK_OE_N_O),
  .SERIAL_RESULT_OUT_O(SERIAL_RESULT_OUT_O), .SERIAL_RESULT_OUT_OE_N_O(SERIAL_RESULT_OUT_OE_N_O),
  .CONFIG_O(CONFIG_O), .POR_ACTIVE_O(POR_ACTIVE_O), .CONV_ACTIVE_O(CONV_ACTIVE_O),
  .CAL_ACTIVE_O(CAL_ACTIVE_O), .CONV_DONE_O(CONV_DONE_O), .SLEEP_O(SLEEP_O));

// *** host_model.sv ***
// host model driving the four-wire serial link
`timescale 1ns/1ns
module host_model (
  input wire sck_o_i,
  input wire sck_oe_n_i,
  input wire sdo_i,
  input wire sdo_oe_n_i,
  output wire sck_pin_o,
  output reg csn_o,
  output reg sdi_o
);
  reg drv = 1'b0;
  reg hsck = 1'b0;
  wire sdo_seen;
  // a released result line reads inverted, so a floating bit never passes as data
  assign sdo_seen = sdo_oe_n_i ? ~sdo_i : sdo_i;
  // idle levels of the host pins
  initial begin
    csn_o = 1'b1;
    sdi_o = 1'b0;
  end
  // clock from the device when enabled, else from the host, else pulled up
  assign sck_pin_o = !sck_oe_n_i ? sck_o_i : (drv ? hsck : 1'b1);
  // one select frame of n clocks, external or internal clock
  task xfer(input integer n, input ext, input [15:0] cfg, output [23:0] w);
    integer i;
    begin
      w = 24'h000000;
      drv = ext;
      hsck = 1'b0;
      sdi_o = cfg[15];
      #40 csn_o = 1'b0;
      // the internal clock starts at once; an external one waits for the wake-up
      if (ext) #200;
      for (i = 0; i < n; i = i + 1) begin
        // config bit set before rising edge
        if (i > 0) sdi_o = (i < 16) ? cfg[15 - i] : ~sdi_o;
        if (ext) #32 hsck = 1'b1;
        else @(posedge sck_pin_o);
        w = {w[22:0], sdo_seen};
        if (ext) #32 hsck = 1'b0;
        else begin
          @(negedge sck_pin_o);
          #2;
        end
      end
      #40 csn_o = 1'b1;
      sdi_o = ~sdi_o;
      #40 drv = 1'b0;
    end
  endtask
endmodule

// *** adc_cycle_ctrl_tb_top.sv ***
// self-checking bench for the converter cycle control block
`timescale 1ns/1ns
module adc_cycle_ctrl_tb_top;
  // ==========================================
  // pins, rows and counters
  reg clk = 1'b0, rstn = 1'b0, sup = 1'b1, osc = 1'b0, ovr = 1'b0, und = 1'b0, sgn = 1'b0;
  reg [16:0] dat = 17'h00000;
  reg [23:0] w;
  reg [59:0] rows [0:2];
  wire csn, sck, sck_o, sck_oen, serial_config_in, serial_result_out, sdo_oen, por, conv, cal, done, slp, imode;
  wire [15:0] cfg;
  integer miscompares = 0, comparisons = 0, r;
  // clock and conversion oscillator
  always #2 clk = ~clk;
  always #8 osc = ~osc;
  adc_cycle_ctrl #(.POR_CYCLES(20'h00010), .CONV_OSC_CYCLES(12'h020), .CAL_OSC_CYCLES(12'h004))
  adc_cycle_ctrl_i (
    .REF_CLK_I(clk), .RSTN_I(rstn), .SUPPLY_OK_I(sup), .CONV_OSC_I(osc), .CSN_I(csn), .SCK_I(sck),
    .SCK_O(sck_o), .SCK_OE_N_O(sck_oen), .SERIAL_CONFIG_IN_I(serial_config_in), .SERIAL_RESULT_OUT_O(serial_result_out),
    .SERIAL_RESULT_OUT_OE_N_O(sdo_oen), .ADC_SIGN_I(sgn), .ADC_DATA_I(dat), .ADC_OVER_I(ovr),
    .ADC_UNDER_I(und), .CONFIG_O(cfg), .POR_ACTIVE_O(por), .CONV_ACTIVE_O(conv), .CAL_ACTIVE_O(cal),
    .CONV_DONE_O(done), .SLEEP_O(slp), .INT_SCK_MODE_O(imode));
  host_model host_model_i (.sck_o_i(sck_o), .sck_oe_n_i(sck_oen), .sdo_i(serial_result_out), .sdo_oe_n_i(sdo_oen),
    .sck_pin_o(sck), .csn_o(csn), .sdi_o(serial_config_in));
  // ==========================================
  // shared tasks
  task chk(input [23:0] seen, input [23:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wait_sleep;
    integer n;
    begin
      n = 0;
      while (slp !== 1'b1 && n < 4000) begin
        @(negedge clk);
        n = n + 1;
      end
      chk(24'(slp), 24'h000001);
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // ==========================================
  // rows: over, under, sign, magnitude, config, word
  initial begin
    rows[0] = {3'h1, 17'h1abcd, 16'h0123, 24'h3abcd0};
    rows[1] = {3'h4, 17'h00005, 16'h5a21, 24'h300000};
    rows[2] = {3'h3, 17'h1ffff, 16'h2b45, 24'h000000};
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    chk(24'(cfg), 24'h000010);
    for (r = 0; r < 3; r = r + 1) begin
      {ovr, und, sgn, dat} = rows[r][59:40];
      wait_sleep;
      host_model_i.xfer(24, 1'b1, rows[r][39:24], w);
      chk(w, rows[r][23:0]);
      chk(24'(imode), 24'h000000);
      chk(24'(serial_result_out), 24'h000001);
      repeat (4) @(negedge clk);
      chk(24'(cfg), 24'(rows[r][39:24]));
      chk(24'(conv), 24'h000001);
    end
    $display("row tests done");
    // select pulse without clocks, then full read of the kept word
    wait_sleep;
    host_model_i.xfer(0, 1'b1, 16'h0000, w);
    repeat (8) @(negedge clk);
    chk(24'(slp), 24'h000001);
    host_model_i.xfer(24, 1'b1, rows[2][39:24], w);
    chk(w, rows[2][23:0]);
    $display("idle select test done");
    // abort after three clocks
    @(negedge clk);
    {ovr, und, sgn, dat} = rows[0][59:40];
    wait_sleep;
    host_model_i.xfer(3, 1'b1, 16'hffff, w);
    chk(w, 24'h000001);
    repeat (8) @(negedge clk);
    chk(24'(conv), 24'h000001);
    chk(24'(cfg), 24'(rows[2][39:24]));
    $display("abort test done");
    // internal clock read
    wait_sleep;
    host_model_i.xfer(24, 1'b0, 16'h0123, w);
    chk(24'(imode), 24'h000001);
    chk(w, rows[0][23:0]);
    chk(24'(sck_oen), 24'h000001);
    $display("internal clock test done");
    // reset in mid-run, then low supply
    @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    chk(24'(por), 24'h000001);
    chk(24'(cfg), 24'h000010);
    chk(24'(sdo_oen), 24'h000001);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    chk(24'(por), 24'h000001);
    repeat (14) @(negedge clk);
    chk(24'(conv), 24'h000001);
    sup = 1'b0;
    repeat (4) @(negedge clk);
    chk(24'(por), 24'h000001);
    sup = 1'b1;
    repeat (30) @(negedge clk);
    chk(24'(conv), 24'h000001);
    $display("reset tests done");
    report_and_stop;
  end
  // watchdog against a hang
  initial begin
    #100000;
    miscompares = miscompares + 1;
    report_and_stop;
  end
endmodule
